// *** rtl/spg_par_gen.sv ***
// Three-bit parity code of one data word and its address.
// Assumes purely combinational use by the wrapper.
`timescale 1ns/1ps
`default_nettype none
module spg_par_gen (
  input wire logic [spg_pkg::DW-1:0] data_in,
  input wire logic [spg_pkg::AW-1:0] addr_in,
  output logic [spg_pkg::PW-1:0] code_out
);
  // ==========================================================
  // Code bits
  // separate data, address bits
  always_comb begin
    code_out = '0;
    code_out[spg_pkg::PAR_LO] = ^data_in[7:0];
    code_out[spg_pkg::PAR_HI] = ^data_in[15:8];
    code_out[spg_pkg::PAR_ADR] = ^addr_in;
  end
endmodule
`default_nettype wire

// *** rtl/spg_pkg.sv ***
// Shared types and constants of the parity-guarded SRAM wrapper.
// Assumes a single system clock; all initiators sit on that clock.
package spg_pkg;
  // ==========================================================
  // Sizes
  localparam int NUM_INI = 3;
  localparam int NUM_BLK = 4;
  localparam int AW = 8;
  localparam int DW = 16;
  localparam int PW = 3;
  localparam int BLK_LSB = 6;
  localparam int BLK_W = 2;
  localparam int INI_W = 2;

  // ==========================================================
  // Initiators and blocks
  localparam logic [INI_W-1:0] INI_CPU = 2'h0;
  localparam logic [INI_W-1:0] INI_MATH = 2'h1;
  localparam logic [INI_W-1:0] INI_DMA = 2'h2;
  localparam logic [INI_W-1:0] INI_LAST = 2'h2;
  localparam logic [BLK_W-1:0] LOCAL_BLK = 2'h0;

  // ==========================================================
  // Parity code layout
  localparam int PAR_LO = 0;
  localparam int PAR_HI = 1;
  localparam int PAR_ADR = 2;
  localparam logic [PW-1:0] PAR_FLIP = 3'h1;
  localparam logic [DW-1:0] DATA_FLIP = 16'h0001;

  // ==========================================================
  // Reset values and blocked-fetch read data
  localparam logic [23:0] PERM_RST = 24'hffffff;
  localparam logic [INI_W-1:0] RR_RST = 2'h0;
  localparam logic [DW-1:0] NO_INSN = 16'h0000;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {SPG_INJ_NONE, SPG_INJ_DATA, SPG_INJ_PAR} spg_inj_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic fetch;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } spg_req_s;

  typedef struct packed {
    logic valid;
    logic [INI_W-1:0] ini;
    logic blocked;
    logic perr;
    logic [DW-1:0] rdata;
    logic [PW-1:0] par;
  } spg_rsp_s;

  typedef struct packed {
    logic fetch_en;
    logic write_en;
  } spg_perm_s;

  typedef spg_perm_s [NUM_BLK-1:0][NUM_INI-1:0] spg_perm_t;
endpackage

// *** rtl/spg_wrapper.sv ***
// SRAM wrapper with parity guard, arbitration and access protection.
// Assumes initiators and permission source share sys_clk_in.
// Behaviour
// - Store 3-bit parity: one bit per data byte, one for address.
// - Generate and check parity inside wrapper, at memory output.
// - Parity mismatch on a read other than a blocked fetch pulses NMI and sets error status.
// - Parity works straight from reset, needs no enable.
// - Test input corrupts stored data or parity on writes.
// - Stored parity code is returned with every read.
// - Per block, per initiator fetch and write enables block accesses.
// - Plain reads are never blocked.
// - Permissions rewritable at run time, apply to later accesses.
// - Local CPU block carries no protection; others do.
// - Round-robin arbiter grants one access per cycle; after granting initiator 1 it skips 1 until 0 or 2 is granted.
`timescale 1ns/1ps
`default_nettype none
module spg_wrapper (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire spg_pkg::spg_req_s [spg_pkg::NUM_INI-1:0] req_in,
  output logic [spg_pkg::NUM_INI-1:0] gnt_out,
  output spg_pkg::spg_rsp_s rsp_out,
  input wire logic perm_we_in,
  input wire spg_pkg::spg_perm_t perm_in,
  input wire spg_pkg::spg_inj_e inj_mode_in,
  input wire logic err_clr_in,
  output logic nmi_out,
  output logic error_status_output_out,
  output logic viol_out,
  output logic [spg_pkg::INI_W-1:0] viol_ini_out
);
  typedef struct packed {
    logic [spg_pkg::INI_W-1:0] rr;
    spg_pkg::spg_perm_t perm;
    logic s1_valid;
    logic [spg_pkg::INI_W-1:0] s1_ini;
    logic s1_blocked;
    logic [spg_pkg::AW-1:0] s1_addr;
    spg_pkg::spg_rsp_s rsp;
    logic nmi;
    logic err_sts;
    logic viol;
    logic [spg_pkg::INI_W-1:0] viol_ini;
  } spg_state_s;

  spg_state_s st_r;
  spg_state_s st_nxt;
  logic [spg_pkg::DW+spg_pkg::PW-1:0] mem_r [2**spg_pkg::AW];
  logic [spg_pkg::DW+spg_pkg::PW-1:0] rword_r;
  logic [spg_pkg::INI_W-1:0] cand;
  logic [spg_pkg::INI_W-1:0] gnt_idx;
  logic gnt_any;
  spg_pkg::spg_req_s sel;
  logic [spg_pkg::BLK_W-1:0] sel_blk;
  logic unprot;
  logic wr_ok;
  logic fetch_ok;
  logic mem_we;
  logic [spg_pkg::PW-1:0] wr_code;
  logic [spg_pkg::PW-1:0] chk_code;
  logic [spg_pkg::DW+spg_pkg::PW-1:0] wword;
  logic perr;

  // ==========================================================
  // Arbiter
  // round-robin single grant; after a grant to 1, initiator 1 waits for a grant to 0 or 2
  always_comb begin
    gnt_any = 1'b0;
    gnt_idx = spg_pkg::RR_RST;
    cand = spg_pkg::RR_RST;
    for (int k = 0; k < spg_pkg::NUM_INI; k++) begin
      cand = st_r.rr + 2'(k);
      if (cand > spg_pkg::INI_LAST) begin
        cand = cand - 2'(spg_pkg::NUM_INI);
      end
      if (!gnt_any && req_in[cand].valid) begin
        gnt_any = 1'b1;
        gnt_idx = cand;
      end
    end
    gnt_out = '0;
    if (gnt_any) begin
      gnt_out[gnt_idx] = 1'b1;
    end
  end

  // ==========================================================
  // Protection check
  always_comb begin
    sel = req_in[gnt_idx];
    sel_blk = sel.addr[spg_pkg::AW-1:spg_pkg::BLK_LSB];
    unprot = (sel_blk == spg_pkg::LOCAL_BLK);
    wr_ok = unprot || st_r.perm[sel_blk][gnt_idx].write_en;
    fetch_ok = unprot || st_r.perm[sel_blk][gnt_idx].fetch_en;
    mem_we = gnt_any && sel.write && wr_ok;
  end

  // ==========================================================
  // Parity generation and check
  spg_par_gen u_wr_par (
    .data_in(sel.wdata),
    .addr_in(sel.addr),
    .code_out(wr_code)
  );

  spg_par_gen u_chk_par (
    .data_in(rword_r[spg_pkg::DW-1:0]),
    .addr_in(st_r.s1_addr),
    .code_out(chk_code)
  );

  // corrupt data or parity on write
  always_comb begin
    wword = {wr_code, sel.wdata};
    if (inj_mode_in == spg_pkg::SPG_INJ_DATA) begin
      wword[spg_pkg::DW-1:0] = sel.wdata ^ spg_pkg::DATA_FLIP;
    end else if (inj_mode_in == spg_pkg::SPG_INJ_PAR) begin
      wword[spg_pkg::DW+spg_pkg::PW-1:spg_pkg::DW] =
        wr_code ^ spg_pkg::PAR_FLIP;
    end
  end

  assign perr = (chk_code != rword_r[spg_pkg::DW+spg_pkg::PW-1:spg_pkg::DW]);

  // ==========================================================
  // Memory array
  always_ff @(posedge sys_clk_in) begin
    if (mem_we) begin
      mem_r[sel.addr] <= wword;
    end
    rword_r <= mem_r[sel.addr];
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.nmi = 1'b0;
    st_nxt.viol = 1'b0;
    st_nxt.rsp.valid = 1'b0;
    if (perm_we_in) begin
      st_nxt.perm = perm_in;
    end
    st_nxt.s1_valid = gnt_any && !sel.write;
    st_nxt.s1_ini = gnt_idx;
    st_nxt.s1_addr = sel.addr;
    st_nxt.s1_blocked = gnt_any && sel.fetch && !fetch_ok;
    if (gnt_any) begin
      st_nxt.rr = (gnt_idx == spg_pkg::INI_LAST) ? spg_pkg::RR_RST :
                  gnt_idx + 2'h1;
    end
    if (gnt_any && ((sel.write && !wr_ok) ||
                    (sel.fetch && !fetch_ok))) begin
      st_nxt.viol = 1'b1;
      st_nxt.viol_ini = gnt_idx;
    end
    if (st_r.s1_valid) begin
      st_nxt.rsp.valid = 1'b1;
      st_nxt.rsp.ini = st_r.s1_ini;
      st_nxt.rsp.blocked = st_r.s1_blocked;
      st_nxt.rsp.perr = perr && !st_r.s1_blocked;
      st_nxt.rsp.rdata = st_r.s1_blocked ? spg_pkg::NO_INSN :
                         rword_r[spg_pkg::DW-1:0];
      st_nxt.rsp.par = rword_r[spg_pkg::DW+spg_pkg::PW-1:spg_pkg::DW];
    end
    if (err_clr_in) begin
      st_nxt.err_sts = 1'b0;
    end
    if (st_r.s1_valid && perr && !st_r.s1_blocked) begin
      st_nxt.nmi = 1'b1;
      st_nxt.err_sts = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r <= '0;
      st_r.perm <= spg_pkg::PERM_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rsp_out = st_r.rsp;
  assign nmi_out = st_r.nmi;
  assign error_status_output_out = st_r.err_sts;
  assign viol_out = st_r.viol;
  assign viol_ini_out = st_r.viol_ini;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  grant_onehot_a: assert property ($onehot0(gnt_out))
    else $error("more than one grant");
  rsp_latency_a: assert property (
    (gnt_any && !sel.write) |-> ##2 (rsp_out.valid &&
      rsp_out.ini == $past(gnt_idx, 2)))
    else $error("read answer not two cycles after grant");
  nmi_on_err_a: assert property (
    (rsp_out.valid && rsp_out.perr) |-> (nmi_out && error_status_output_out))
    else $error("parity error without nmi and status");
  err_sticky_a: assert property (
    (error_status_output_out && !err_clr_in) |=> error_status_output_out)
    else $error("error status dropped without clear");
  perm_update_a: assert property (
    perm_we_in |=> (st_r.perm == $past(perm_in)))
    else $error("permission write not applied");
  read_open_a: assert property (
    (gnt_any && !sel.write && !sel.fetch) |=> !viol_out ##1 !rsp_out.blocked)
    else $error("plain read was blocked");
  local_open_a: assert property (
    (gnt_any && unprot) |=> !viol_out)
    else $error("local block access flagged");
  blocked_write_a: assert property (
    (gnt_any && sel.write && !wr_ok) |-> (!mem_we ##1 viol_out))
    else $error("disallowed write not blocked");
  blocked_fetch_a: assert property (
    (rsp_out.valid && rsp_out.blocked) |->
      (rsp_out.rdata == spg_pkg::NO_INSN && !nmi_out))
    else $error("blocked fetch returned data");
  inject_par_a: assert property (
    (mem_we && inj_mode_in == spg_pkg::SPG_INJ_PAR) |->
      (((wword[spg_pkg::DW+spg_pkg::PW-1:spg_pkg::DW] ^ wr_code) ==
        spg_pkg::PAR_FLIP) && (wword[spg_pkg::DW-1:0] == sel.wdata)))
    else $error("parity injection had no effect");
endmodule
`default_nettype wire

// *** verification/spg_ini_model.sv ***
// Bus initiators (cpu, math coprocessor, dma) facing the wrapper.
// Assumes requests start on a rising edge and hold until granted.
`timescale 1ns/1ps
`default_nettype none
module spg_ini_model (
  input wire logic sys_clk_in,
  input wire logic [spg_pkg::NUM_INI-1:0] gnt_in,
  output var spg_pkg::spg_req_s [spg_pkg::NUM_INI-1:0] req_out
);
  // ==========================================================
  // Request issue
  initial req_out = '0;

  task automatic issue(input int i, input logic w, input logic f,
      input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    req_out[i] <= '{1'b1, w, f, a, d};
    do @(posedge sys_clk_in); while (gnt_in[i] !== 1'b1);
    // Released fields show junk, not the last value
    req_out[i] <= '{1'b0, ~w, ~f, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench of the parity-guarded SRAM wrapper.
// Assumes the initiator model in spg_ini_model.sv.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic perm_we = 1'b0;
  logic err_clr = 1'b0;
  spg_pkg::spg_perm_t perm = spg_pkg::PERM_RST;
  spg_pkg::spg_inj_e inj = spg_pkg::SPG_INJ_NONE;
  spg_pkg::spg_req_s [spg_pkg::NUM_INI-1:0] req;
  logic [spg_pkg::NUM_INI-1:0] gnt;
  spg_pkg::spg_rsp_s rsp;
  logic nmi, err_sts, viol;
  logic [1:0] viol_ini;
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;

  always #4 sys_clk_in = ~sys_clk_in;

  spg_wrapper dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .req_in(req), .gnt_out(gnt), .rsp_out(rsp), .perm_we_in(perm_we),
    .perm_in(perm), .inj_mode_in(inj), .err_clr_in(err_clr),
    .nmi_out(nmi), .error_status_output_out(err_sts),
    .viol_out(viol), .viol_ini_out(viol_ini));
  spg_ini_model ini (.sys_clk_in(sys_clk_in), .gnt_in(gnt),
    .req_out(req));

  // ==========================================================
  // Helpers
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  function automatic logic [2:0] pe(input logic [7:0] a,
      input logic [15:0] d);
    return {^a, ^d[15:8], ^d[7:0]};
  endfunction

  task automatic wr(input int i, input logic [7:0] a,
      input logic [15:0] d, input logic v);
    ini.issue(i, 1'b1, 1'b0, a, d);
    #1;
    cmp(viol, v);
    if (v) cmp(viol_ini, i[1:0]);
  endtask

  task automatic rd(input int i, input logic f, input logic [7:0] a,
      input logic [15:0] d, input logic [2:0] p, input logic b,
      input logic e);
    ini.issue(i, 1'b0, f, a, ~d);
    #1;
    cmp(viol, b);
    @(posedge sys_clk_in);
    #1;
    cmp({rsp.valid, rsp.ini, rsp.blocked}, {1'b1, i[1:0], b});
    cmp({rsp.perr, nmi}, {e, e});
    cmp(rsp.rdata, d);
    if (!b) cmp(rsp.par, p);
  endtask

  task automatic set_perm(input spg_pkg::spg_perm_t p);
    @(posedge sys_clk_in);
    perm <= p;
    perm_we <= 1'b1;
    @(posedge sys_clk_in);
    perm_we <= 1'b0;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_par;
    wr(0, 8'h45, 16'h1234, 1'b0);
    rd(0, 1'b0, 8'h45, 16'h1234, pe(8'h45, 16'h1234), 1'b0, 1'b0);
    wr(1, 8'hc1, 16'hfedc, 1'b0);
    rd(2, 1'b0, 8'hc1, 16'hfedc, pe(8'hc1, 16'hfedc), 1'b0, 1'b0);
    $display("test parity done");
  endtask

  task automatic t_inj;
    @(posedge sys_clk_in);
    inj <= spg_pkg::SPG_INJ_DATA;
    wr(0, 8'h46, 16'h00ff, 1'b0);
    @(posedge sys_clk_in);
    inj <= spg_pkg::SPG_INJ_PAR;
    wr(1, 8'h87, 16'h0f0f, 1'b0);
    @(posedge sys_clk_in);
    inj <= spg_pkg::SPG_INJ_NONE;
    rd(0, 1'b0, 8'h46, 16'h00ff ^ spg_pkg::DATA_FLIP,
       pe(8'h46, 16'h00ff), 1'b0, 1'b1);
    cmp(err_sts, 1'b1);
    rd(1, 1'b0, 8'h87, 16'h0f0f,
       pe(8'h87, 16'h0f0f) ^ spg_pkg::PAR_FLIP, 1'b0, 1'b1);
    @(posedge sys_clk_in);
    err_clr <= 1'b1;
    @(posedge sys_clk_in);
    err_clr <= 1'b0;
    @(posedge sys_clk_in);
    #1;
    cmp(err_sts, 1'b0);
    $display("test inject done");
  endtask

  task automatic t_prot;
    spg_pkg::spg_perm_t p;
    p = spg_pkg::PERM_RST;
    p[1][2] = '0;
    p[0][2] = '0;
    set_perm(p);
    wr(2, 8'h45, 16'hdead, 1'b1);
    rd(2, 1'b0, 8'h45, 16'h1234, pe(8'h45, 16'h1234), 1'b0, 1'b0);
    rd(2, 1'b1, 8'h45, spg_pkg::NO_INSN, 3'h0, 1'b1, 1'b0);
    rd(0, 1'b1, 8'h45, 16'h1234, pe(8'h45, 16'h1234), 1'b0, 1'b0);
    wr(2, 8'h05, 16'h0bad, 1'b0);
    rd(2, 1'b1, 8'h05, 16'h0bad, pe(8'h05, 16'h0bad), 1'b0, 1'b0);
    set_perm(spg_pkg::PERM_RST);
    wr(2, 8'h45, 16'hbeef, 1'b0);
    rd(2, 1'b1, 8'h45, 16'hbeef, pe(8'h45, 16'hbeef), 1'b0, 1'b0);
    $display("test protect done");
  endtask

  task automatic t_arb;
    int t0, t1, t2;
    fork
      begin
        ini.issue(0, 1'b1, 1'b0, 8'h81, 16'h1111);
        t0 = cyc;
      end
      begin
        ini.issue(1, 1'b1, 1'b0, 8'h82, 16'h2222);
        t1 = cyc;
      end
      begin
        ini.issue(2, 1'b1, 1'b0, 8'h83, 16'h3333);
        t2 = cyc;
      end
    join
    cmp(t1 - t0, 32'h1);
    cmp(t2 - t1, 32'h1);
    rd(1, 1'b0, 8'h81, 16'h1111, pe(8'h81, 16'h1111), 1'b0, 1'b0);
    rd(2, 1'b0, 8'h82, 16'h2222, pe(8'h82, 16'h2222), 1'b0, 1'b0);
    rd(0, 1'b0, 8'h83, 16'h3333, pe(8'h83, 16'h3333), 1'b0, 1'b0);
    $display("test arbitration done");
  endtask

  // ==========================================================
  // Monitor, timeout and verdict
  always @(posedge sys_clk_in) begin
    if (rstn_in) cmp($countones(gnt) <= 1, 1'b1);
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      num_errors++;
      give_verdict();
    end
  end

  initial begin
    repeat (2) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    #1;
    cmp(err_sts, 1'b0);
    t_par();
    t_inj();
    t_prot();
    t_arb();
    give_verdict();
  end
endmodule
`default_nettype wire
